//--- include/ccm_defs.svh
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// ****************************************************************
// register addresses (register_select_bits)
// ****************************************************************
`define CCM_ADDR_MONITOR 6'h08
`define CCM_ADDR_SLOT_FIRST 6'h09
`define CCM_ADDR_SLOT_LAST 6'h18

// ****************************************************************
// reset values
// ****************************************************************
`define CCM_RST_MONITOR 8'h00
`define CCM_RST_SLOT0 16'h8001
`define CCM_RST_SLOTN 16'h0001

// ****************************************************************
// slot register fields
// ****************************************************************
`define CCM_F_ENABLE 15
`define CCM_F_SETUP_HI 14
`define CCM_F_SETUP_LO 12
`define CCM_F_POS_HI 9
`define CCM_F_POS_LO 5
`define CCM_F_NEG_HI 4
`define CCM_F_NEG_LO 0

// ****************************************************************
// serial command byte and data word widths
// ****************************************************************
`define CCM_CMD_READ_BIT 6
`define CCM_CMD_BITS 8
`define CCM_MON_BITS 8
`define CCM_SLOT_BITS 16

// ****************************************************************
// timing
// ****************************************************************
`define CCM_CLK_HZ 100000000
`define CCM_FS_FULL_HZ 614400
`define CCM_FS_MID_HZ 153600
`define CCM_FS_LOW_HZ 768000
`define CCM_MON_DIV 131

`endif

//--- include/ccm_pkg.sv
package ccm_pkg;

	// power mode selects the sampling clock rate
	typedef enum logic [1:0] {
		CCM_PWR_LOW,
		CCM_PWR_MID,
		CCM_PWR_FULL
	} ccm_pwr_type;

	// serial access phases
	typedef enum logic [1:0] {
		CCM_PH_CMD,
		CCM_PH_READ,
		CCM_PH_WRITE,
		CCM_PH_DONE
	} ccm_phase_type;

	// shifter state
	typedef struct packed {
		logic [15:0] sh;
	} ccm_shift_state_type;

	// main block state
	typedef struct packed {
		logic [27:0] acc;
		logic [7:0] pre;
		logic [7:0] mon;
		logic [15:0][15:0] slot;
		logic [3:0] cur;
		logic running;
		logic [3:0] status;
		logic [7:0] cmd;
		logic [4:0] bitcnt;
		ccm_phase_type phase;
		logic sdo_en;
	} ccm_state_type;

endpackage : ccm_pkg

//--- hw/ccm_shifter.sv
`timescale 1ns/1ps
`include "ccm_defs.svh"

// ****************************************************************
// msb-first shift register for serial register access
// ****************************************************************
module ccm_shifter
	import ccm_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic [15:0] i_load_data,
	input wire logic i_shift,
	input wire logic i_sin,
	output logic o_msb,
	output logic [15:0] o_word
);

	ccm_shift_state_type st_ff;
	ccm_shift_state_type nxt_st;

	// load wins over shift; data moves toward the msb
	always_comb begin
		nxt_st = st_ff;
		if (i_load) begin
			nxt_st.sh = i_load_data;
		end else if (i_shift) begin
			nxt_st.sh = {st_ff.sh[14:0], i_sin};
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_msb = st_ff.sh[WIDTH-1];
	assign o_word = st_ff.sh;

endmodule : ccm_shifter

//--- hw/ccm_top.sv
`timescale 1ns/1ps
`include "ccm_defs.svh"

module ccm_top
	import ccm_pkg::*;
#(
	parameter int NUM_SLOTS = 16,
	parameter int MON_DIV = `CCM_MON_DIV
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire ccm_pwr_type i_power_mode,
	input wire logic i_frame,
	input wire logic i_bit_en,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_en,
	input wire logic i_conv_run,
	input wire logic i_conv_done,
	output logic o_conv_active,
	output logic [3:0] o_cur_slot,
	output logic [2:0] o_cur_setup,
	output logic [4:0] o_cur_pos_input_select,
	output logic [4:0] o_cur_neg_input_select,
	output logic [3:0] o_status_slot
);

	// ****************************************************************
	// constants
	// ****************************************************************
	localparam logic [27:0] CLK_HZ = 28'(`CCM_CLK_HZ);
	localparam logic [27:0] FS_FULL = 28'(`CCM_FS_FULL_HZ);
	localparam logic [27:0] FS_MID = 28'(`CCM_FS_MID_HZ);
	localparam logic [27:0] FS_LOW = 28'(`CCM_FS_LOW_HZ);
	localparam logic [7:0] PRE_LAST = 8'(MON_DIV - 1);
	localparam logic [4:0] CMD_LAST = 5'(`CCM_CMD_BITS - 1);

	ccm_state_type st_ff;
	ccm_state_type nxt_st;

	logic [27:0] fs_inc;
	logic [28:0] acc_sum;
	logic samp_tick;
	logic [NUM_SLOTS-1:0] en_vec;
	logic any_en;
	logic [3:0] lowest_en;
	logic [3:0] next_en;
	logic [5:0] rs_addr;
	logic is_mon;
	logic is_slot;
	logic [3:0] slot_idx;
	logic [15:0] rd_word;
	logic [4:0] data_bits;
	logic cmd_done;
	logic sh_load;
	logic sh_shift;
	logic sh_msb;
	logic [15:0] sh_word;

	// ****************************************************************
	// sampling clock enable
	// ****************************************************************

	always_comb begin
		case (i_power_mode)
			CCM_PWR_FULL: fs_inc = FS_FULL;
			CCM_PWR_MID: fs_inc = FS_MID;
			default: fs_inc = FS_LOW;
		endcase
	end

	// fractional accumulator: 100 MHz is no integer multiple of the rates
	assign acc_sum = {1'b0, st_ff.acc} + {1'b0, fs_inc};
	assign samp_tick = (acc_sum >= {1'b0, CLK_HZ});

	// ****************************************************************
	// slot enable scan
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_en
			assign en_vec[gi] = st_ff.slot[gi][`CCM_F_ENABLE];
		end
	endgenerate

	assign any_en = |en_vec;

	always_comb begin
		lowest_en = '0;
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			if (en_vec[i]) begin
				lowest_en = 4'(i);
			end
		end
	end

	always_comb begin
		logic found;
		logic [3:0] idx;
		found = 1'b0;
		idx = '0;
		next_en = lowest_en;
		for (int i = 1; i <= NUM_SLOTS; i++) begin
			idx = 4'(st_ff.cur + 4'(i));
			if (!found && en_vec[idx]) begin
				next_en = idx;
				found = 1'b1;
			end
		end
	end

	// ****************************************************************
	// serial address decode
	// ****************************************************************
	// the last select bit is still on the pin as the command completes,
	// so the read word must be chosen from it, not from the stale byte
	assign rs_addr = cmd_done ? {st_ff.cmd[4:0], i_sdi} : st_ff.cmd[5:0];
	assign slot_idx = 4'(rs_addr - `CCM_ADDR_SLOT_FIRST);

	// slot window; unmapped reads return zero
	always_comb begin
		is_mon = 1'b0;
		is_slot = 1'b0;
		if (rs_addr == `CCM_ADDR_MONITOR) begin
			is_mon = 1'b1;
		end else if (rs_addr >= `CCM_ADDR_SLOT_FIRST &&
			rs_addr <= `CCM_ADDR_SLOT_LAST) begin
			is_slot = 1'b1;
		end
	end

	// count sampled as is, no guard against a coincident increment
	always_comb begin
		rd_word = '0;
		data_bits = 5'(`CCM_SLOT_BITS);
		if (is_mon) begin
			// eight-bit value left-justified so bit 7 leaves first
			rd_word = {st_ff.mon, 8'h00};
			data_bits = 5'(`CCM_MON_BITS);
		end else if (is_slot) begin
			rd_word = st_ff.slot[slot_idx];
		end
	end

	assign cmd_done = i_frame && i_bit_en &&
		st_ff.phase == CCM_PH_CMD && st_ff.bitcnt == CMD_LAST;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		sh_load = 1'b0;
		sh_shift = 1'b0;

		// one monitor step per 131 sampling pulses
		if (samp_tick) begin
			nxt_st.acc = 28'(acc_sum - {1'b0, CLK_HZ});
			if (st_ff.pre == PRE_LAST) begin
				nxt_st.pre = '0;
				nxt_st.mon = st_ff.mon + 8'h01;
			end else begin
				nxt_st.pre = st_ff.pre + 8'h01;
			end
		end else begin
			nxt_st.acc = 28'(acc_sum);
		end

		// serial engine: command byte then msb-first data
		if (!i_frame) begin
			nxt_st.phase = CCM_PH_CMD;
			nxt_st.bitcnt = '0;
			nxt_st.sdo_en = 1'b0;
		end else if (i_bit_en) begin
			case (st_ff.phase)
				CCM_PH_CMD: begin
					nxt_st.cmd = {st_ff.cmd[6:0], i_sdi};
					nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
					if (cmd_done) begin
						nxt_st.bitcnt = '0;
						if (st_ff.cmd[`CCM_CMD_READ_BIT - 1]) begin
							nxt_st.phase = CCM_PH_READ;
							nxt_st.sdo_en = 1'b1;
						end else begin
							nxt_st.phase = CCM_PH_WRITE;
						end
					end
				end
				CCM_PH_READ: begin
					sh_shift = 1'b1;
					nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
					if (st_ff.bitcnt == data_bits - 5'h01) begin
						nxt_st.phase = CCM_PH_DONE;
						nxt_st.sdo_en = 1'b0;
					end
				end
				CCM_PH_WRITE: begin
					sh_shift = 1'b1;
					nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
					if (st_ff.bitcnt == data_bits - 5'h01) begin
						nxt_st.phase = CCM_PH_DONE;
						// monitor writes dropped; bits 11:10 kept as sent
						if (is_slot) begin
							nxt_st.slot[slot_idx] = {sh_word[14:0], i_sdi};
						end
					end
				end
				default: begin
					nxt_st.bitcnt = st_ff.bitcnt;
				end
			endcase
		end

		// shifter preloads the read word as the command byte completes
		if (cmd_done) begin
			sh_load = 1'b1;
		end

		if (!i_conv_run || !any_en) begin
			nxt_st.running = 1'b0;
			nxt_st.cur = lowest_en;
		end else if (!st_ff.running) begin
			nxt_st.running = 1'b1;
			nxt_st.cur = lowest_en;
		end else if (i_conv_done) begin
			nxt_st.cur = next_en;
		end

		// tag result with slot number
		// a finished slot is tagged even if run drops in the same cycle
		if (st_ff.running && i_conv_done) begin
			nxt_st.status = st_ff.cur;
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_ff.acc <= '0;
			st_ff.pre <= '0;
			st_ff.mon <= `CCM_RST_MONITOR;
			for (int i = 0; i < NUM_SLOTS; i++) begin
				st_ff.slot[i] <= (i == 0) ? `CCM_RST_SLOT0 : `CCM_RST_SLOTN;
			end
			st_ff.cur <= '0;
			st_ff.running <= 1'b0;
			st_ff.status <= '0;
			st_ff.cmd <= '0;
			st_ff.bitcnt <= '0;
			st_ff.phase <= CCM_PH_CMD;
			st_ff.sdo_en <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// serial shifter
	// ****************************************************************
	ccm_shifter #(
		.WIDTH(16)
	) u_shift (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_load(sh_load),
		.i_load_data(rd_word),
		.i_shift(sh_shift),
		.i_sin(i_sdi),
		.o_msb(sh_msb),
		.o_word(sh_word)
	);

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign o_sdo = st_ff.sdo_en & sh_msb;
	assign o_sdo_en = st_ff.sdo_en;
	assign o_conv_active = st_ff.running;
	assign o_cur_slot = st_ff.cur;
	// setup index for the active slot
	assign o_cur_setup =
		st_ff.slot[st_ff.cur][`CCM_F_SETUP_HI:`CCM_F_SETUP_LO];
	assign o_cur_pos_input_select =
		st_ff.slot[st_ff.cur][`CCM_F_POS_HI:`CCM_F_POS_LO];
	assign o_cur_neg_input_select =
		st_ff.slot[st_ff.cur][`CCM_F_NEG_HI:`CCM_F_NEG_LO];
	assign o_status_slot = st_ff.status;

endmodule : ccm_top

//--- sim/ccm_top_sva.sv
`timescale 1ns/1ps
// **********************************************
// port checks for serial port and sequencer
// **********************************************
module ccm_top_sva
	import ccm_pkg::*;
#(
	parameter int NUM_SLOTS = 16,
	parameter int MON_DIV = 131
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_frame,
	input wire logic i_bit_en,
	input wire logic o_sdo,
	input wire logic o_sdo_en,
	input wire logic i_conv_run,
	input wire logic i_conv_done,
	input wire logic o_conv_active,
	input wire logic [3:0] o_cur_slot,
	input wire logic [3:0] o_status_slot
);
	// single clock domain, so clocking and disable are shared
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_sdo_quiet: assert property (!o_sdo_en |-> !o_sdo)
		else $error("read data driven while disabled");
	a_sdo_framed: assert property (o_sdo_en |-> $past(i_frame))
		else $error("read data outside a frame");
	a_sdo_start: assert property ($rose(o_sdo_en) |-> $past(i_bit_en))
		else $error("read data began without a bit time");
	a_bit_hold: assert property (
		o_sdo_en && i_frame && !i_bit_en |=> $stable(o_sdo))
		else $error("read bit moved between bit times");
	a_idle_quiet: assert property (
		!i_frame ##1 !i_frame |-> !o_sdo_en)
		else $error("read data driven while idle");
	a_run_off: assert property (!i_conv_run |=> !o_conv_active)
		else $error("sequencer active without run");
	a_status_take: assert property (
		i_conv_done && o_conv_active |=> o_status_slot == $past(o_cur_slot))
		else $error("status does not name finished slot");
	a_status_hold: assert property (
		!i_conv_done |=> $stable(o_status_slot))
		else $error("status moved without a finished slot");
	// frame guard: enable writes may legally move the slot
	a_slot_hold: assert property (
		!i_frame ##1 (!i_frame && o_conv_active && i_conv_run && !i_conv_done)
		|=> $stable(o_cur_slot) || !o_conv_active)
		else $error("slot moved without a finished slot");
endmodule : ccm_top_sva

//--- sim/ccm_host_model.sv
`timescale 1ns/1ps
// **********************************************
// host controller on the serial port
// **********************************************
module ccm_host_model (
	input wire logic i_clk,
	input wire logic i_sdo,
	input wire logic i_sdo_en,
	output logic o_frame,
	output logic o_bit_en,
	output logic o_sdi
);
	initial begin
		o_frame = 1'b0;
		o_bit_en = 1'b0;
		o_sdi = 1'b0;
	end
	// one framed access; gap idle cycles per bit gives a slow host
	task automatic access(input logic [7:0] cmd, input logic [15:0] wd,
		input int nbits, input int gap, output logic [15:0] rd,
		output int bad);
		logic [23:0] sh;
		sh = {cmd, wd << (16 - nbits)};
		rd = 16'h0000;
		bad = 0;
		@(posedge i_clk);
		#1 o_frame = 1'b1;
		for (int i = 0; i < 8 + nbits; i++) begin
			repeat (gap) begin
				@(posedge i_clk);
				#1 o_bit_en = 1'b0;
				o_sdi = ~o_sdi;
			end
			@(posedge i_clk);
			#1 o_bit_en = 1'b1;
			o_sdi = sh[23];
			sh = sh << 1;
			if (i >= 8) begin
				rd = {rd[14:0], i_sdo};
				if (cmd[6] && i_sdo_en !== 1'b1) bad++;
			end
		end
		@(posedge i_clk);
		#1 o_bit_en = 1'b0;
		o_frame = 1'b0;
		o_sdi = ~o_sdi; // released line must not look stable
		@(posedge i_clk);
		#1;
	endtask : access
endmodule : ccm_host_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "ccm_defs.svh"
// **********************************************
// register bank bench
// **********************************************
module tb_top;
	import ccm_pkg::*;
	localparam int MON_DIV = 3;
	logic i_clk, i_rst, i_frame, i_bit_en, i_sdi, o_sdo, o_sdo_en;
	logic i_conv_run, i_conv_done, o_conv_active;
	logic [3:0] o_cur_slot, o_status_slot;
	logic [2:0] o_cur_setup;
	logic [4:0] o_cur_pos_input_select, o_cur_neg_input_select;
	ccm_pwr_type i_power_mode;
	logic [15:0] d;
	logic [15:0] cfg [16];
	int n_errors, cmp_count, gap, prv, bad;
	int seq [4] = '{3, 15, 0, 3};
	real ticks;
	ccm_top #(.NUM_SLOTS(16), .MON_DIV(MON_DIV)) i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_power_mode(i_power_mode),
		.i_frame(i_frame), .i_bit_en(i_bit_en), .i_sdi(i_sdi),
		.o_sdo(o_sdo), .o_sdo_en(o_sdo_en), .i_conv_run(i_conv_run),
		.i_conv_done(i_conv_done), .o_conv_active(o_conv_active),
		.o_cur_slot(o_cur_slot), .o_cur_setup(o_cur_setup),
		.o_cur_pos_input_select(o_cur_pos_input_select),
		.o_cur_neg_input_select(o_cur_neg_input_select),
		.o_status_slot(o_status_slot));
	ccm_host_model i_host (.i_clk(i_clk), .i_sdo(o_sdo),
		.i_sdo_en(o_sdo_en), .o_frame(i_frame), .o_bit_en(i_bit_en),
		.o_sdi(i_sdi));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	function automatic real fs_hz(input ccm_pwr_type m);
		case (m)
			CCM_PWR_LOW: return `CCM_FS_LOW_HZ;
			CCM_PWR_MID: return `CCM_FS_MID_HZ;
			default: return `CCM_FS_FULL_HZ;
		endcase
	endfunction : fs_hz
	// reference count of sampling pulses since reset
	always @(posedge i_clk) begin
		if (i_rst) ticks <= 0.0;
		else ticks <= ticks + fs_hz(i_power_mode) / 1.0e8;
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// the phase of the real divider is unknown, so allow one count
	task automatic chk_near(input int e, input logic [15:0] g);
		cmp_count++;
		if ($isunknown(g) || int'(g) > e + 1 || int'(g) < e - 1) begin
			n_errors++;
			$display("wrong value monitor expected %0d seen %h", e, g);
		end
	endtask : chk_near
	task automatic rd(input logic [5:0] a, input int n,
		output logic [15:0] q);
		i_host.access({2'b01, a}, 16'h0000, n, gap, q, bad);
		chk("read enable", 16'h0000, 16'(bad));
	endtask : rd
	task automatic wr(input logic [5:0] a, input int n, input logic [15:0] v);
		i_host.access({2'b00, a}, v, n, gap, d, bad);
	endtask : wr
	task automatic chk_cur(input int c);
		chk("active", 16'h0001, {15'h0000, o_conv_active});
		chk("slot", 16'(c), {12'h000, o_cur_slot});
		chk("fields", {3'b000, cfg[c][14:12], cfg[c][9:0]}, {3'b000,
			o_cur_setup, o_cur_pos_input_select,
			o_cur_neg_input_select});
	endtask : chk_cur
	task automatic give_verdict();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		i_rst = 1'b1;
		i_power_mode = CCM_PWR_FULL;
		i_conv_run = 1'b0;
		i_conv_done = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		gap = 0;
		repeat (16) @(posedge i_clk);
		#1 i_rst = 1'b0;
		// monitor is read-only and starts from zero
		wr(`CCM_ADDR_MONITOR, 8, 16'h00A5);
		rd(`CCM_ADDR_MONITOR, 8, d);
		chk("monitor", 16'h0000, d);
		for (int k = 0; k < 16; k++) begin
			cfg[k] = (k == 0) ? 16'h8001 : 16'h0001;
			rd(6'(`CCM_ADDR_SLOT_FIRST + k), 16, d);
			chk("slot reset", cfg[k], d);
		end
		rd(6'h19, 16, d);
		chk("unmapped", 16'h0000, d);
		// two slots naming the same inputs, one written slowly
		cfg[3] = {1'b1, 3'h5, 2'b00, 5'h12, 5'h03};
		cfg[15] = {1'b1, 3'h2, 2'b00, 5'h12, 5'h03};
		gap = 2;
		wr(6'h0C, 16, cfg[3]);
		rd(6'h0C, 16, d);
		chk("slot 3", cfg[3], d);
		gap = 0;
		wr(`CCM_ADDR_SLOT_LAST, 16, cfg[15]);
		i_conv_run = 1'b1;
		@(posedge i_clk);
		#1 chk_cur(0);
		// back-to-back finished conversions walk up and wrap
		prv = 0;
		i_conv_done = 1'b1;
		for (int j = 0; j < 4; j++) begin
			@(posedge i_clk);
			#1 chk_cur(seq[j]);
			chk("status", 16'(prv), {12'h000, o_status_slot});
			prv = seq[j];
		end
		i_conv_done = 1'b0;
		// nothing enabled stops the sequencer
		for (int j = 0; j < 3; j++) begin
			cfg[seq[j]][15] = 1'b0;
			wr(6'(9 + seq[j]), 16, cfg[seq[j]]);
		end
		@(posedge i_clk);
		#1 chk("idle", 16'h0000, {15'h0000, o_conv_active});
		cfg[7] = {1'b1, 3'h7, 2'b00, 5'h1D, 5'h1C};
		wr(6'h10, 16, cfg[7]);
		@(posedge i_clk);
		#1 chk_cur(7);
		// four reads per group, one group in each power mode
		for (int m = 0; m < 3; m++) begin
			i_power_mode = ccm_pwr_type'(m);
			repeat (2000) @(posedge i_clk);
			#1;
			repeat (4) begin
				rd(`CCM_ADDR_MONITOR, 8, d);
				chk_near(int'($floor(ticks / MON_DIV)) % 256, d);
			end
		end
		give_verdict();
	end
endmodule : tb_top
bind ccm_top ccm_top_sva #(.NUM_SLOTS(NUM_SLOTS), .MON_DIV(MON_DIV)) i_sva (
	.i_clk(i_clk), .i_rst(i_rst), .i_frame(i_frame), .i_bit_en(i_bit_en),
	.o_sdo(o_sdo), .o_sdo_en(o_sdo_en), .i_conv_run(i_conv_run),
	.i_conv_done(i_conv_done), .o_conv_active(o_conv_active),
	.o_cur_slot(o_cur_slot), .o_status_slot(o_status_slot));
